// ---- design/ctc_pkg.sv ----
// Package of constants for the camera trigger control block
package ctc_pkg;
    // Register byte offsets
    localparam logic [7:0] CTC_CTRL_OFS    = 8'h00;
    localparam logic [7:0] CTC_SOURCE_OFS  = 8'h04;
    localparam logic [7:0] CTC_ROWS_OFS    = 8'h08;
    localparam logic [7:0] CTC_IMAGES_OFS  = 8'h0c;
    localparam logic [7:0] CTC_HEIGHT_OFS  = 8'h10;
    localparam logic [7:0] CTC_COMMAND_OFS = 8'h14;
    localparam logic [7:0] CTC_STATUS_OFS  = 8'h18;
    // Control register fields
    localparam int CTC_TYPE_BIT      = 0;
    localparam int CTC_EN_ROW_BIT    = 1;
    localparam int CTC_EN_IMAGE_BIT  = 2;
    localparam int CTC_MULTI_BIT     = 3;
    localparam int CTC_OVL_LSB       = 4;
    // Source register fields
    localparam int CTC_ORIGIN_LSB    = 0;
    localparam int CTC_QUAL_LSB      = 4;
    // Status register fields
    localparam int CTC_ST_ACTIVE_BIT = 0;
    localparam int CTC_ST_ISROW_BIT  = 1;
    localparam int CTC_ST_PEND_BIT   = 2;
    localparam int CTC_ST_BADSRC_BIT = 3;
    localparam int CTC_ST_EXP_BIT    = 4;
    // Reset values
    localparam logic [15:0] CTC_ROWS_RST   = 16'h0001;
    localparam logic [15:0] CTC_IMAGES_RST = 16'h0001;
    localparam logic [15:0] CTC_HEIGHT_RST = 16'h0400;
    localparam logic [1:0]  AXI_OKAY   = 2'h0;
    localparam logic [1:0]  AXI_SLVERR = 2'h2;

    typedef enum logic { single_row_capture, single_image_capture } ctc_trig_type;
    typedef enum logic [1:0] { input_pin_one, input_pin_two, shaft_position_source,
                               ctc_origin_none } ctc_origin_type;
    typedef enum logic [1:0] { posedge_valid, both_edges_valid, active_high_valid,
                               active_low_valid } ctc_qual_type;
    typedef enum logic [1:0] { ctc_overlap_off, ctc_overlap_readout,
                               latch_during_prior_row, ctc_overlap_rsvd } ctc_overlap_type;
endpackage

// ---- design/ctc_qualify.sv ----
// Synchroniser and edge or level qualifier for one trigger input
`timescale 1ns/1ns
`default_nettype none
module ctc_qualify (
    input  wire logic       clk,      // Clock
    input  wire logic       resetn,   // Sync reset, active low
    input  wire logic       pin,      // Raw trigger input
    input  wire logic [1:0] mode,     // Qualify mode
    output logic            fire      // Qualified trigger; one cycle in edge modes, held while valid in level modes
);
    logic sync1_reg, sync2_reg, last_reg, fire_reg;
    logic sync1_next, sync2_next, last_next, fire_next;

    always_comb begin
        sync1_next = pin;
        sync2_next = sync1_reg;
        last_next  = sync2_reg;
        unique case (ctc_pkg::ctc_qual_type'(mode))
            ctc_pkg::posedge_valid:     fire_next = sync2_reg & ~last_reg;
            ctc_pkg::both_edges_valid:  fire_next = sync2_reg ^ last_reg;
            ctc_pkg::active_high_valid: fire_next = sync2_reg;
            ctc_pkg::active_low_valid:  fire_next = ~sync2_reg;
        endcase
    end

    // Two stages before any look at the level; edge pulses last one cycle
    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            last_reg  <= 1'b0;
            fire_reg  <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            last_reg  <= last_next;
            fire_reg  <= fire_next;
        end
    end

    assign fire = fire_reg;
endmodule
`default_nettype wire

// ---- design/ctc_top.sv ----
// Camera trigger control with AXI4-Lite registers
//
// Contract
// - Selector picks row or image trigger type
// - Image trigger captures image height rows
// - Per-type enable; off means trigger ignored (the host command still triggers with the enable off)
// - Images per trigger, only in multi-image
// - Each row trigger captures programmed row count
// - Host command triggers regardless of origin
// - Origin drives capture only when enabled
// - Origins: pin one, pin two, shaft encoder
// - Origin validated against trigger type
// - Qualify applies only to external pins
// - Posedge mode: rising transition is trigger
// - Both-edges mode: every transition triggers
// - Active-high mode: valid while high
// - Active-low mode: valid while low
// - Overlap policy accepts or latches triggers
// - Off rejects; readout accepts after exposure
// - Prior-row option latches, applies afterwards
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ctc_top #(
    parameter int CNT_W = 16
) (
    input  wire logic        clk,           // Clock, 250 MHz
    input  wire logic        resetn,        // Sync reset, active low
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire logic        input_pin_one, // External trigger pin one
    input  wire logic        input_pin_two, // External trigger pin two
    input  wire logic        shaft_pulse,   // Encoder output pulse
    input  wire logic        row_done,      // Sequencer: current row finished
    input  wire logic        exposure_done, // Sequencer: exposure ended
    output logic             row_start,     // Pulse: start one row
    output logic             active         // Capture in progress
);
    // Register state
    logic             type_reg, en_row_reg, en_img_reg, multi_reg;
    logic [1:0]       ovl_reg, origin_reg, qual_reg;
    logic [CNT_W-1:0] rows_reg, images_reg, height_reg;
    logic             type_next, en_row_next, en_img_next, multi_next;
    logic [1:0]       ovl_next, origin_next, qual_next;
    logic [CNT_W-1:0] rows_next, images_next, height_next;
    logic             sw_reg, sw_next;
    // Bus state
    logic             aw_got_reg, w_got_reg, bvalid_reg, rvalid_reg;
    logic             aw_got_next, w_got_next, bvalid_next, rvalid_next;
    logic [7:0]       awaddr_reg, awaddr_next;
    logic [31:0]      wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic [3:0]       wstrb_reg, wstrb_next;
    logic [1:0]       bresp_reg, bresp_next, rresp_reg, rresp_next;
    // Sequencer state
    typedef enum logic [1:0] { ctc_idle, ctc_wait_row, ctc_issue } ctc_seq_type;
    ctc_seq_type      st_reg, st_next;
    logic [CNT_W-1:0] row_cnt_reg, row_cnt_next, img_cnt_reg, img_cnt_next;
    logic             pend_reg, pend_next, exp_reg, exp_next;
    logic             start_reg, start_next, active_reg, active_next;

    logic [2:0] fire;
    logic       pin_fire, origin_ok, trig_en, trig;

    // One qualifier per source so each keeps its own edge history
    ctc_qualify u_q1 (.clk(clk), .resetn(resetn), .pin(input_pin_one),
                      .mode(qual_reg), .fire(fire[0]));
    ctc_qualify u_q2 (.clk(clk), .resetn(resetn), .pin(input_pin_two),
                      .mode(qual_reg), .fire(fire[1]));
    // Encoder is already a pulse train: fixed rising-edge
    ctc_qualify u_q3 (.clk(clk), .resetn(resetn), .pin(shaft_pulse),
                      .mode(ctc_pkg::posedge_valid), .fire(fire[2]));

    always_comb begin
        // Encoder is a row source only
        unique case (ctc_pkg::ctc_origin_type'(origin_reg))
            ctc_pkg::input_pin_one:         origin_ok = 1'b1;
            ctc_pkg::input_pin_two:         origin_ok = 1'b1;
            ctc_pkg::shaft_position_source: origin_ok = (type_reg == 1'b0);
            ctc_pkg::ctc_origin_none:       origin_ok = 1'b0;
        endcase
        // Index three is never used: origin_ok masks it
        pin_fire = origin_ok & fire[origin_reg];
        trig_en  = type_reg ? en_img_reg : en_row_reg;
        trig     = sw_reg | (trig_en & pin_fire);
    end

    // Register bus
    logic        wr_go, rd_go, wr_bad;
    logic [31:0] wmask, rword;
    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next  = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next  = wdata_reg;
        wstrb_next  = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        type_next = type_reg;    en_row_next = en_row_reg;
        en_img_next = en_img_reg; multi_next = multi_reg;
        ovl_next = ovl_reg;      origin_next = origin_reg;
        qual_next = qual_reg;    rows_next = rows_reg;
        images_next = images_reg; height_next = height_reg;
        // Host trigger lasts one cycle and bypasses enable and origin
        sw_next = 1'b0;
        wr_bad = 1'b0;
        if (s_axi_awvalid && !aw_got_reg) begin
            aw_got_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_reg) begin
            w_got_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        // Commit only with both halves held and no answer still pending
        wr_go = aw_got_reg && w_got_reg && !bvalid_reg;
        wmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
        if (wr_go) begin
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
            bvalid_next = 1'b1;
            unique case (awaddr_reg)
                ctc_pkg::CTC_CTRL_OFS: begin
                    if (wmask[0]) begin
                        type_next   = wdata_reg[ctc_pkg::CTC_TYPE_BIT];
                        en_row_next = wdata_reg[ctc_pkg::CTC_EN_ROW_BIT];
                        en_img_next = wdata_reg[ctc_pkg::CTC_EN_IMAGE_BIT];
                        multi_next  = wdata_reg[ctc_pkg::CTC_MULTI_BIT];
                        ovl_next    = wdata_reg[ctc_pkg::CTC_OVL_LSB +: 2];
                    end
                end
                ctc_pkg::CTC_SOURCE_OFS: begin
                    if (wmask[0]) begin
                        origin_next = wdata_reg[ctc_pkg::CTC_ORIGIN_LSB +: 2];
                        qual_next   = wdata_reg[ctc_pkg::CTC_QUAL_LSB +: 2];
                    end
                end
                ctc_pkg::CTC_ROWS_OFS:
                    rows_next = (rows_reg & ~wmask[CNT_W-1:0]) | (wdata_reg[CNT_W-1:0] & wmask[CNT_W-1:0]);
                ctc_pkg::CTC_IMAGES_OFS:
                    images_next = (images_reg & ~wmask[CNT_W-1:0]) | (wdata_reg[CNT_W-1:0] & wmask[CNT_W-1:0]);
                ctc_pkg::CTC_HEIGHT_OFS:
                    height_next = (height_reg & ~wmask[CNT_W-1:0]) | (wdata_reg[CNT_W-1:0] & wmask[CNT_W-1:0]);
                ctc_pkg::CTC_COMMAND_OFS:
                    sw_next = wmask[0] & wdata_reg[0];
                ctc_pkg::CTC_STATUS_OFS: ;
                default: wr_bad = 1'b1;
            endcase
            bresp_next = wr_bad ? ctc_pkg::AXI_SLVERR : ctc_pkg::AXI_OKAY;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        // Unmapped or unaligned reads answer an error with zero data
        rword = 32'h0000_0000;
        rd_go = s_axi_arvalid && !rvalid_reg;
        rresp_next = rresp_reg;
        unique case (s_axi_araddr)
            ctc_pkg::CTC_CTRL_OFS:   rword = {26'h0, ovl_reg, multi_reg, en_img_reg,
                                              en_row_reg, type_reg};
            ctc_pkg::CTC_SOURCE_OFS: rword = {26'h0, qual_reg, 2'h0, origin_reg};
            ctc_pkg::CTC_ROWS_OFS:   rword[CNT_W-1:0] = rows_reg;
            ctc_pkg::CTC_IMAGES_OFS: rword[CNT_W-1:0] = images_reg;
            ctc_pkg::CTC_HEIGHT_OFS: rword[CNT_W-1:0] = height_reg;
            ctc_pkg::CTC_COMMAND_OFS: rword = 32'h0000_0000;
            ctc_pkg::CTC_STATUS_OFS: rword = {27'h0, exp_reg, ~origin_ok, pend_reg,
                                              (st_reg != ctc_idle) & ~type_reg, active_reg};
            default: rword = 32'h0000_0000;
        endcase
        if (rd_go) begin
            rvalid_next = 1'b1;
            rdata_next  = rword;
            rresp_next  = (s_axi_araddr > ctc_pkg::CTC_STATUS_OFS || s_axi_araddr[1:0] != 2'h0)
                          ? ctc_pkg::AXI_SLVERR : ctc_pkg::AXI_OKAY;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // Capture sequencer
    always_comb begin
        st_next      = st_reg;
        row_cnt_next = row_cnt_reg;
        img_cnt_next = img_cnt_reg;
        pend_next    = pend_reg;
        exp_next     = exp_reg;
        start_next   = 1'b0;
        active_next  = active_reg;
        unique case (st_reg)
            ctc_idle: begin
                if (trig || pend_reg) begin
                    pend_next   = 1'b0;
                    active_next = 1'b1;
                    exp_next    = 1'b0;
                    // Image: height rows times image count in multi-image, else one image; row: row count
                    row_cnt_next = type_reg ? height_reg : rows_reg;
                    img_cnt_next = (type_reg && multi_reg) ? images_reg : CNT_W'(1);
                    st_next = ctc_issue;
                end
            end
            ctc_issue: begin
                start_next = 1'b1;
                exp_next   = 1'b0;
                // A trigger in the launch cycle still overlaps this row
                if (trig && !type_reg && ovl_reg == 2'(ctc_pkg::latch_during_prior_row))
                    pend_next = 1'b1;
                st_next    = ctc_wait_row;
            end
            ctc_wait_row: begin
                if (exposure_done)
                    exp_next = 1'b1;
                // Overlap: off rejects; readout after exposure; prior-row any time
                if (trig && !type_reg) begin
                    if (ovl_reg == 2'(ctc_pkg::latch_during_prior_row))
                        pend_next = 1'b1;
                    else if (ovl_reg == 2'(ctc_pkg::ctc_overlap_readout) && (exp_reg || exposure_done))
                        pend_next = 1'b1;
                end // image triggers and overlap off are dropped here
                // Last row of the last image ends the burst
                if (row_done) begin
                    if (row_cnt_reg > CNT_W'(1)) begin
                        row_cnt_next = row_cnt_reg - CNT_W'(1);
                        st_next = ctc_issue;
                    end else if (img_cnt_reg > CNT_W'(1)) begin
                        img_cnt_next = img_cnt_reg - CNT_W'(1);
                        row_cnt_next = height_reg;
                        st_next = ctc_issue;
                    end else begin
                        active_next = 1'b0;
                        st_next = ctc_idle;
                    end
                end
            end
            default: st_next = ctc_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            type_reg <= 1'b0;   en_row_reg <= 1'b0;  en_img_reg <= 1'b0;
            multi_reg <= 1'b0;  ovl_reg <= 2'h0;     origin_reg <= 2'h0;
            qual_reg <= 2'h0;   sw_reg <= 1'b0;
            // Package values are 16 bits; sized to the counter width
            rows_reg <= CNT_W'(ctc_pkg::CTC_ROWS_RST);
            images_reg <= CNT_W'(ctc_pkg::CTC_IMAGES_RST);
            height_reg <= CNT_W'(ctc_pkg::CTC_HEIGHT_RST);
            aw_got_reg <= 1'b0; w_got_reg <= 1'b0;  awaddr_reg <= 8'h00;
            wdata_reg <= 32'h0; wstrb_reg <= 4'h0;  bvalid_reg <= 1'b0;
            bresp_reg <= 2'h0;  rvalid_reg <= 1'b0; rdata_reg <= 32'h0;
            rresp_reg <= 2'h0;
            st_reg <= ctc_idle; row_cnt_reg <= '0;  img_cnt_reg <= '0;
            pend_reg <= 1'b0;   exp_reg <= 1'b0;
            start_reg <= 1'b0;  active_reg <= 1'b0;
        end else begin
            type_reg <= type_next;     en_row_reg <= en_row_next;
            en_img_reg <= en_img_next; multi_reg <= multi_next;
            ovl_reg <= ovl_next;       origin_reg <= origin_next;
            qual_reg <= qual_next;     sw_reg <= sw_next;
            rows_reg <= rows_next;     images_reg <= images_next;
            height_reg <= height_next;
            aw_got_reg <= aw_got_next; w_got_reg <= w_got_next;
            awaddr_reg <= awaddr_next; wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;   bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;   rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;   rresp_reg <= rresp_next;
            st_reg <= st_next;         row_cnt_reg <= row_cnt_next;
            img_cnt_reg <= img_cnt_next;
            pend_reg <= pend_next;     exp_reg <= exp_next;
            start_reg <= start_next;   active_reg <= active_next;
        end
    end

    // Each ready drops while its channel holds an item
    assign s_axi_awready = ~aw_got_reg;
    assign s_axi_wready  = ~w_got_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = ~rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign row_start     = start_reg;
    assign active        = active_reg;
endmodule
`default_nettype wire

// ---- tb/ctc_top_sva.sv ----
// Checker of bus answer timing and row burst timing at the top ports
`timescale 1ns/1ns
`default_nettype none
module ctc_top_sva #(
    parameter int CNT_W = 16
) (
    input wire logic        clk,           // Clock
    input wire logic        resetn,        // Sync reset, active low
    input wire logic        s_axi_awvalid, // Write address valid
    input wire logic        s_axi_awready, // Write address ready
    input wire logic        s_axi_wvalid,  // Write data valid
    input wire logic        s_axi_wready,  // Write data ready
    input wire logic [1:0]  s_axi_bresp,   // Write response
    input wire logic        s_axi_bvalid,  // Write response valid
    input wire logic        s_axi_bready,  // Write response ready
    input wire logic        s_axi_arvalid, // Read address valid
    input wire logic        s_axi_arready, // Read address ready
    input wire logic [31:0] s_axi_rdata,   // Read data
    input wire logic [1:0]  s_axi_rresp,   // Read response
    input wire logic        s_axi_rvalid,  // Read data valid
    input wire logic        s_axi_rready,  // Read data ready
    input wire logic        row_done,      // Row finished
    input wire logic        row_start,     // Row start pulse
    input wire logic        active         // Capture in progress
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_ROW_PULSE: assert property (row_start |=> !row_start)
        else $error("row start pulse wider than one cycle");
    AST_ROW_ACTIVE: assert property (row_start |=> active)
        else $error("active low during a row");
    AST_ACTIVE_END: assert property ($fell(active) |-> $past(row_done))
        else $error("active fell without a finished row");
    AST_B_ORDER: assert property ($rose(s_axi_bvalid) |-> !$past(s_axi_awready)
        && !$past(s_axi_wready))
        else $error("write answer before both halves were held");
    AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read answer changed before rready");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp))
        else $error("write answer changed before bready");

    CV_ROW: cover property (row_start);
    CV_END: cover property ($fell(active));
    CV_BWAIT: cover property (s_axi_bvalid && !s_axi_bready);
endmodule
`default_nettype wire

// ---- tb/ctc_far_model.sv ----
// Far-side model: trigger pins, shaft encoder and row sequencer replies
`timescale 1ns/1ns
`default_nettype none
module ctc_far_model (
    input  wire logic clk,           // Clock
    input  wire logic resetn,        // Sync reset, active low
    input  wire logic lvl_one,       // Wanted level of pin one
    input  wire logic lvl_two,       // Wanted level of pin two
    input  wire logic enc_go,        // Request one encoder pulse
    input  wire logic slow,          // Slow row replies
    input  wire logic row_start,     // Row request from block
    output logic      input_pin_one, // Trigger pin one
    output logic      input_pin_two, // Trigger pin two
    output logic      shaft_pulse,   // Encoder output
    output logic      row_done,      // Row finished
    output logic      exposure_done  // Exposure ended
);
    int cnt = 0;
    // Slow replies keep a row open for an overlapping trigger and end exposure late
    always @(posedge clk) begin
        input_pin_one <= lvl_one;
        input_pin_two <= lvl_two;
        shaft_pulse <= enc_go;
        exposure_done <= resetn & (slow ? (cnt == 10) : row_start);
        row_done <= (cnt == 1) & resetn;
        if (!resetn) cnt <= 0;
        else if (row_start) cnt <= slow ? 16 : 2;
        else if (cnt > 0) cnt <= cnt - 1;
    end
endmodule
`default_nettype wire

// ---- tb/ctc_top_test.sv ----
// Self-checking bench for the camera trigger control block
`timescale 1ns/1ns
`default_nettype none
module ctc_top_test;
    logic        clk = 0, resetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, lvl_one = 0, lvl_two = 0, enc_go = 0;
    logic        slow = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, row_start, active, input_pin_one, input_pin_two, shaft_pulse;
    logic        row_done, exposure_done;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
    int          error_cnt = 0, n_checks = 0, rows_seen = 0, base = 0;
    localparam logic [7:0]  RST_OFS [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    localparam logic [31:0] RST_VAL [7] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h400, 32'h0, 32'h0};

    ctc_top dut (.*);
    ctc_far_model far (.*);
    initial forever #2 clk = ~clk;
    always @(posedge clk) if (row_start === 1'b1) rows_seen <= rows_seen + 1;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task print_verdict;
        $display("Checks %0d, errors %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp = 2'h0);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        repeat (200) begin
            @(posedge clk);
            if (s_axi_bvalid && s_axi_bready) break;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= s_axi_bvalid;
        end
        check(32'(s_axi_bvalid && s_axi_bready), 32'h1);
        s_axi_bready <= 1'b0;
        check(32'(s_axi_bresp), 32'(exp));
    endtask

    task axi_read(input logic [7:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        repeat (200) begin
            @(posedge clk);
            if (s_axi_rvalid && s_axi_rready) break;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= s_axi_rvalid;
        end
        check(32'(s_axi_rvalid && s_axi_rready), 32'h1);
        s_axi_rready <= 1'b0;
        rd = s_axi_rdata;
        rr = s_axi_rresp;
    endtask

    // Rows count from the last run, since a register write may fire a trigger itself
    task run(input logic v, input logic tog, input int exp);
        lvl_one <= v;
        repeat (40) begin
            @(posedge clk);
            if (rows_seen != base || row_start === 1'b1) break;
        end
        if (tog) lvl_one <= ~v;
        repeat (2) begin
            repeat (3000) begin
                @(posedge clk);
                if (active === 1'b0) break;
            end
            repeat (12) @(posedge clk);
        end
        check(rows_seen - base, exp);
        check(32'(active), 32'h0);
        base = rows_seen;
    endtask

    task t_reset;
        for (int i = 0; i < 7; i++) begin
            axi_read(RST_OFS[i]);
            check(rd, RST_VAL[i]);
            check(32'(rr), 32'(ctc_pkg::AXI_OKAY));
        end
        axi_read(8'h20);
        check(32'(rr), 32'(ctc_pkg::AXI_SLVERR));
        axi_write(8'h1c, 32'h1, ctc_pkg::AXI_SLVERR);
    endtask

    task t_host;
        axi_write(8'h08, 32'h3);
        axi_write(8'h14, 32'h1);
        run(1'b0, 1'b0, 3);
    endtask

    task t_enable;
        run(1'b1, 1'b0, 0);
        axi_write(8'h00, 32'h2);
        run(1'b0, 1'b0, 0);
        run(1'b1, 1'b0, 3);
        axi_write(8'h04, 32'h10);
        run(1'b0, 1'b0, 3);
        run(1'b1, 1'b0, 3);
    endtask

    task t_level;
        axi_write(8'h08, 32'h1);
        slow <= 1'b1;
        axi_write(8'h04, 32'h30);
        run(1'b0, 1'b1, 1);
        axi_write(8'h04, 32'h20);
        run(1'b1, 1'b1, 1);
    endtask

    task t_source;
        axi_write(8'h04, 32'h01);
        run(1'b1, 1'b0, 0);
        lvl_two <= 1'b1;
        run(1'b1, 1'b0, 1);
        // Low qualify on a low encoder line would fire if wrongly applied
        axi_write(8'h04, 32'h32);
        run(1'b1, 1'b0, 0);
        enc_go <= 1'b1;
        @(posedge clk);
        enc_go <= 1'b0;
        run(1'b1, 1'b0, 1);
    endtask

    task t_overlap;
        axi_write(8'h04, 32'h10);
        for (int k = 0; k < 3; k++) begin
            axi_write(8'h00, 32'h2 | (k << 4));
            // Second edge lands before exposure ends: only prior-row keeps it
            run(~lvl_one, 1'b1, (k == 2) ? 2 : 1);
        end
        // Readout keeps an edge that comes once exposure has ended
        axi_write(8'h00, 32'h12);
        lvl_one <= ~lvl_one;
        repeat (40) begin
            @(posedge clk);
            if (row_start === 1'b1) break;
        end
        repeat (8) @(posedge clk);
        run(~lvl_one, 1'b0, 2);
    endtask

    task t_image;
        axi_write(8'h04, 32'h00);
        axi_write(8'h10, 32'h2);
        axi_write(8'h0c, 32'h2);
        axi_write(8'h00, 32'h0d);
        run(1'b0, 1'b0, 0);
        run(1'b1, 1'b0, 4);
        axi_write(8'h00, 32'h05);
        run(1'b0, 1'b0, 0);
        run(1'b1, 1'b0, 2);
        axi_write(8'h04, 32'h02);
        axi_read(8'h18);
        check(32'(rd[3]), 32'h1);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        resetn <= 1'b1;
        t_reset;
        t_host;
        t_enable;
        t_level;
        t_source;
        t_overlap;
        t_image;
        print_verdict;
    end

    initial begin
        #200000;
        error_cnt++;
        print_verdict;
    end
endmodule

bind ctc_top ctc_top_sva #(.CNT_W(CNT_W)) u_sva (.*);
`default_nettype wire
